// ---- logic/csc_tx.sv ----
/*
  Transmitting end: cell sequencing with start, sync and idle symbol
  pairs, scrambling, 4b/5b encoding, serialising and NRZI coding.
  Assumes i_ce marks one line bit time and the cell source holds data.
*/
module csc_tx #(
  parameter int unsigned P_RESET_CYCLES = csc_pkg::RESET_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cell_valid,
  input csc_pkg::csc_octet_t i_cell_data,
  output logic o_cell_ready,
  input wire logic i_sync_event,
  output logic o_underrun,
  csc_link_if.tx_end link
);
  import csc_pkg::*;

  typedef enum logic [5:0] {
    ST_FILL_HI = 6'h01,
    ST_FILL_LO = 6'h02,
    ST_CMD_ESC = 6'h04,
    ST_CMD_ARG = 6'h08,
    ST_DATA_HI = 6'h10,
    ST_DATA_LO = 6'h20
  } csc_tx_state_t;

  csc_tx_state_t state;
  csc_tx_state_t next_state;
  csc_code_t cmd_sym;
  csc_code_t next_cmd_sym;
  csc_code_t next_sym;
  csc_octet_t octet;
  csc_octet_t in_octet;
  logic [5:0] octets_left;
  logic [2:0] bit_cnt;
  logic [4:0] sym_sh;
  logic [9:0] prng;
  logic [31:0] timer;
  logic last_esc;
  logic next_esc;
  logic sync_pend;
  logic reset_due;
  logic line;
  logic boundary;
  logic pair_end;
  logic start_cell;

  ////////////////////////////////////////////////////////////////////////
  // pair decisions
  assign boundary = i_ce && (bit_cnt == SYM_LAST_BIT);
  assign pair_end = state inside {ST_FILL_LO, ST_CMD_ARG, ST_DATA_LO};
  assign o_cell_ready = boundary && pair_end && !sync_pend && (octets_left != 6'h00);
  assign start_cell = pair_end && !sync_pend && (octets_left == 6'h00) && i_cell_valid;
  assign in_octet = i_cell_valid ? i_cell_data : 8'h00;
  assign next_esc = (next_sym == ESC_SYMBOL);
  assign link.line = line;

  always_comb
  begin
    next_state = state;
    next_cmd_sym = cmd_sym;
    case (state)
      ST_FILL_HI: next_state = ST_FILL_LO;
      ST_CMD_ESC: next_state = ST_CMD_ARG;
      ST_DATA_HI: next_state = ST_DATA_LO;
      ST_FILL_LO, ST_CMD_ARG, ST_DATA_LO:
      begin
        if (sync_pend)
        begin
          next_state = ST_CMD_ESC;
          next_cmd_sym = csc_encode(ARG_SYNC);
        end
        else if (octets_left != 6'h00)
          next_state = ST_DATA_HI;
        else if (i_cell_valid)
        begin
          next_state = ST_CMD_ESC;
          next_cmd_sym = reset_due ? ESC_SYMBOL : csc_encode(ARG_START_KEEP);
        end
        else
          next_state = ST_FILL_HI;
      end
      default: next_state = ST_FILL_LO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // scramble then encode the next symbol
  always_comb
  begin
    case (next_state)
      ST_CMD_ESC: next_sym = ESC_SYMBOL;
      ST_CMD_ARG: next_sym = cmd_sym;
      ST_DATA_HI: next_sym = csc_encode(in_octet[7:4] ^ csc_prng_nib(prng));
      ST_DATA_LO: next_sym = csc_encode(octet[3:0] ^ csc_prng_nib(prng));
      default: next_sym = csc_encode(FILL_NIBBLE ^ csc_prng_nib(prng));
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_FILL_LO;
      cmd_sym <= ESC_SYMBOL;
    end
    else if (boundary)
    begin
      state <= next_state;
      cmd_sym <= next_cmd_sym;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cell octets
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      octet <= 8'h00;
      octets_left <= 6'h00;
    end
    else if (boundary)
    begin
      if (o_cell_ready)
      begin
        octet <= in_octet;
        octets_left <= 6'(octets_left - 6'h01);
      end
      else if (start_cell)
        octets_left <= CELL_OCTETS;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_underrun <= 1'b0;
    else if (i_ce)
      o_underrun <= o_cell_ready && !i_cell_valid;
  end

  ////////////////////////////////////////////////////////////////////////
  // generator: reset on two escapes, otherwise advance
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prng <= PRNG_INIT;
      last_esc <= 1'b0;
    end
    else if (boundary)
    begin
      prng <= (next_esc && last_esc) ? PRNG_INIT : csc_prng_next(prng);
      last_esc <= next_esc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync request and generator reset timer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sync_pend <= 1'b0;
    else if (i_ce)
      sync_pend <= i_sync_event || (sync_pend && !(boundary && pair_end));
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer <= 32'h0000_0000;
      reset_due <= 1'b1;
    end
    else if (i_ce)
    begin
      if (boundary && start_cell && reset_due)
      begin
        timer <= 32'h0000_0000;
        reset_due <= 1'b0;
      end
      else if (timer >= P_RESET_CYCLES - 1)
        reset_due <= 1'b1;
      else
        timer <= timer + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serialise msb first, then nrzi
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bit_cnt <= SYM_LAST_BIT;
      sym_sh <= 5'h00;
      line <= 1'b0;
    end
    else if (i_ce)
    begin
      line <= line ^ sym_sh[4];
      if (bit_cnt == SYM_LAST_BIT)
      begin
        bit_cnt <= 3'h0;
        sym_sh <= next_sym;
      end
      else
      begin
        bit_cnt <= bit_cnt + 3'h1;
        sym_sh <= {sym_sh[3:0], 1'b0};
      end
    end
  end

endmodule : csc_tx

// ---- logic/csc_pkg.sv ----
/*
  Shared constants, types and coding functions of the cell scrambler and
  4b/5b line codec: generator step, symbol table and symbol decoding.
  Assumes both ends run on one clock with a bit-rate clock enable.
*/
package csc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // rates and timing
  localparam int LINE_RATE_KBPS = 25600;
  localparam int CELL_RATE_KBPS = 25125;
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int RESET_MIN_US = 100;
  localparam int RESET_MAX_US = 500000;
  localparam int RESET_INTERVAL_US = 1000;
  localparam int RESET_CYCLES = RESET_INTERVAL_US * CLK_FREQ_KHZ / 1000;

  ////////////////////////////////////////////////////////////////////////
  // cell, generator and symbol constants
  localparam logic [5:0] CELL_OCTETS = 6'h35;
  localparam logic [9:0] PRNG_INIT = 10'h3ff;
  localparam int PRNG_STEPS = 4;
  localparam logic [63:0] PRNG_REF = 64'hf083_cfe8_c7cc_7d43;
  localparam logic [2:0] SYM_LAST_BIT = 3'h4;
  localparam logic [4:0] ESC_SYMBOL = 5'h02;
  localparam logic [3:0] ARG_START_KEEP = 4'h4;
  localparam logic [3:0] ARG_SYNC = 4'h8;
  localparam logic [3:0] FILL_NIBBLE = 4'h0;

  typedef logic [7:0] csc_octet_t;
  typedef logic [4:0] csc_code_t;
  typedef struct packed {
    logic valid;
    logic esc;
    logic [3:0] nib;
  } csc_sym_t;

  ////////////////////////////////////////////////////////////////////////
  // generator: four steps of x^10 + x^7 + 1, bit 0 is x1
  function automatic logic [9:0] csc_prng_next(input logic [9:0] s);
    logic [9:0] r;
    r = s;
    for (int i = 0; i < PRNG_STEPS; i++)
    begin
      r = {r[8:0], r[9] ^ r[6]};
    end
    return r;
  endfunction : csc_prng_next

  // taps x1..x4, x1 meets the high data bit
  function automatic logic [3:0] csc_prng_nib(input logic [9:0] s);
    return {s[0], s[1], s[2], s[3]};
  endfunction : csc_prng_nib

  ////////////////////////////////////////////////////////////////////////
  // symbol table, run length at most five
  function automatic csc_code_t csc_encode(input logic [3:0] n);
    csc_code_t c;
    case (n)
      4'h0: c = 5'h15;
      4'h1: c = 5'h09;
      4'h2: c = 5'h0a;
      4'h3: c = 5'h0b;
      4'h4: c = 5'h07;
      4'h5: c = 5'h0d;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h19;
      4'ha: c = 5'h1a;
      4'hb: c = 5'h1b;
      4'hc: c = 5'h17;
      4'hd: c = 5'h1d;
      4'he: c = 5'h1e;
      default: c = 5'h1f;
    endcase
    return c;
  endfunction : csc_encode

  function automatic csc_sym_t csc_decode(input csc_code_t c);
    csc_sym_t d;
    d.valid = (c == ESC_SYMBOL);
    d.esc = (c == ESC_SYMBOL);
    d.nib = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (csc_encode(4'(i)) == c)
      begin
        d.valid = 1'b1;
        d.nib = 4'(i);
      end
    end
    return d;
  endfunction : csc_decode

endpackage : csc_pkg

// ---- logic/csc_link_if.sv ----
/*
  Serial line between the transmitting and the receiving end.
  Assumes both ends share one clock and one bit-rate clock enable.
*/
interface csc_link_if;
  logic line;
  modport tx_end (output line);
  modport rx_end (input line);
endinterface : csc_link_if

// ---- logic/csc_rx.sv ----
/*
  Receiving end: NRZI decoding, symbol alignment on the escape symbol,
  5b/4b decoding, command handling, descrambling and cell reassembly.
  Assumes the line comes from logic on the same clock and bit enable.
*/
// How it works
// - Line 25 600 kbit/s, cells 25 125.
// - All 53 cell octets scrambled and encoded.
// - Ten-bit generator on x^10 + x^7 + 1.
// - Generator steps four times per nibble.
// - Command nibbles pass unscrambled, generator still moves.
// - Nibble XOR taps x1..x4, high first.
// - Two consecutive escapes load all ones.
// - Next data nibble then uses value F.
// - Generator resets or advances, never holds.
// - Start pair then command gives second reset.
// - Reset at first cell and on timer.
// - Generator nibbles follow the reference sequence.
// - Seventeen valid codes, fifteen are invalid.
// - Nibbles 0 to 7 symbol mapping.
// - Nibbles 8 to F symbol mapping.
// - Escape is 00010, unique comma.
// - Line runs of equal bits stay within five.
// - Transmit order: scramble, encode, then NRZI.
// - Receive: NRZI, decode, descramble, build octets.
// - Escape commands: start, start keep, sync.
// - Symbols sent msb first, then NRZI.
// - Idle sends scrambled filler, never escape.
module csc_rx (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  csc_link_if.rx_end link,
  output csc_pkg::csc_octet_t o_octet,
  output logic o_octet_valid,
  output logic o_sop,
  output logic o_eop,
  output logic o_sync_event,
  output logic o_code_err,
  output logic o_cmd_err,
  output logic o_cell_abort,
  output logic o_aligned
);
  import csc_pkg::*;

  logic line_prev;
  logic line_bit;
  csc_code_t win;
  csc_code_t next_win;
  logic [2:0] bit_cnt;
  logic sym_edge;
  csc_sym_t dec;
  logic [9:0] prng;
  logic [3:0] pnib;
  logic last_esc;
  logic in_cmd;
  logic [5:0] octets_left;
  logic cell_open;
  logic half;
  logic [3:0] hi_nib;

  ////////////////////////////////////////////////////////////////////////
  // nrzi decode and symbol window
  assign line_bit = link.line ^ line_prev;
  assign next_win = {win[3:0], line_bit};
  assign sym_edge = i_ce && ((next_win == ESC_SYMBOL) || (o_aligned && bit_cnt == SYM_LAST_BIT));
  assign dec = csc_decode(next_win);
  assign pnib = csc_prng_nib(prng);
  assign cell_open = (octets_left != 6'h00);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      line_prev <= 1'b0;
      win <= 5'h00;
    end
    else if (i_ce)
    begin
      line_prev <= link.line;
      win <= next_win;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alignment on the escape comma
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bit_cnt <= 3'h0;
      o_aligned <= 1'b0;
    end
    else if (i_ce)
    begin
      if (next_win == ESC_SYMBOL)
        o_aligned <= 1'b1;
      if (sym_edge || bit_cnt == SYM_LAST_BIT)
        bit_cnt <= 3'h0;
      else
        bit_cnt <= bit_cnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // descrambler generator
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prng <= PRNG_INIT;
      last_esc <= 1'b0;
    end
    else if (sym_edge)
    begin
      if (dec.esc && last_esc)
        prng <= PRNG_INIT;
      else
        prng <= csc_prng_next(prng);
      last_esc <= dec.esc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // commands and cell reassembly
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      in_cmd <= 1'b0;
      octets_left <= 6'h00;
      half <= 1'b0;
      hi_nib <= 4'h0;
      o_octet <= 8'h00;
      o_octet_valid <= 1'b0;
      o_sop <= 1'b0;
      o_eop <= 1'b0;
      o_sync_event <= 1'b0;
      o_code_err <= 1'b0;
      o_cmd_err <= 1'b0;
      o_cell_abort <= 1'b0;
    end
    else if (i_ce)
    begin
      o_octet_valid <= 1'b0;
      o_sop <= 1'b0;
      o_eop <= 1'b0;
      o_sync_event <= 1'b0;
      o_code_err <= 1'b0;
      o_cmd_err <= 1'b0;
      o_cell_abort <= 1'b0;
      if (sym_edge)
      begin
        if (!dec.valid)
        begin
          o_code_err <= 1'b1;
          o_cell_abort <= cell_open;
          octets_left <= 6'h00;
          in_cmd <= 1'b0;
        end
        else if (in_cmd)
        begin
          in_cmd <= 1'b0;
          if (dec.esc || dec.nib == ARG_START_KEEP)
          begin
            octets_left <= CELL_OCTETS;
            half <= 1'b0;
            o_cell_abort <= cell_open;
          end
          else if (dec.nib == ARG_SYNC)
            o_sync_event <= 1'b1;
          else
          begin
            o_cmd_err <= 1'b1;
            o_cell_abort <= cell_open;
            octets_left <= 6'h00;
          end
        end
        else if (dec.esc)
          in_cmd <= 1'b1;
        else if (cell_open)
        begin
          if (!half)
          begin
            hi_nib <= dec.nib ^ pnib;
            half <= 1'b1;
          end
          else
          begin
            o_octet <= {hi_nib, dec.nib ^ pnib};
            o_octet_valid <= 1'b1;
            o_sop <= (octets_left == CELL_OCTETS);
            o_eop <= (octets_left == 6'h01);
            octets_left <= 6'(octets_left - 6'h01);
            half <= 1'b0;
          end
        end
      end
    end
  end

endmodule : csc_rx

// ---- test/csc_link_props.sv ----
/*
  Concurrent checks on the link between transmit and receive ends.
  Assumes one clock, i_ce held high, instantiated beside the link.
*/
module csc_link_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic line,
  input wire logic i_cell_valid,
  input wire logic o_cell_ready,
  input wire logic i_sync_event,
  input wire logic o_underrun,
  input wire logic o_octet_valid,
  input wire logic o_sop,
  input wire logic o_eop,
  input wire logic o_sync_event,
  input wire logic o_code_err,
  input wire logic o_aligned,
  input wire logic o_code_err_b,
  input wire logic o_octet_valid_b
);
  logic prev_line;
  logic [3:0] run_len;
  logic [5:0] oct_cnt;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////
  // line run length and octet count
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prev_line <= 1'b0;
      run_len <= 4'h0;
    end
    else
    begin
      prev_line <= line;
      run_len <= (line == prev_line) ? run_len + 4'h1 : 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      oct_cnt <= 6'h00;
    else if (o_octet_valid)
      oct_cnt <= o_sop ? 6'h01 : oct_cnt + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // sync command steps
  sequence s_sync_req;
    i_sync_event && o_aligned;
  endsequence

  sequence s_sync_seen;
    ##[10:40] o_sync_event;
  endsequence

  line_run_a: assert property (run_len <= 4'h5)
    else $error("line run too long");
  sync_fwd_a: assert property (s_sync_req |-> s_sync_seen)
    else $error("sync command not received");
  ready_gap_a: assert property (o_cell_ready |=> !o_cell_ready [*8])
    else $error("octets taken too close");
  underrun_mark_a: assert property (o_cell_ready && !i_cell_valid |=> o_underrun)
    else $error("underrun not flagged");
  sop_first_a: assert property (o_sop |-> o_octet_valid && !o_eop)
    else $error("start marker misplaced");
  eop_count_a: assert property (o_eop |-> o_octet_valid && oct_cnt == 6'h34)
    else $error("end marker not on octet 53");
  octet_gap_a: assert property (o_octet_valid |=> !o_octet_valid [*8])
    else $error("octets closer than a pair");
  code_err_a: assert property (o_code_err_b |=> !o_octet_valid_b [*8])
    else $error("invalid code passed as data");
  clean_line_a: assert property (o_aligned |-> !o_code_err)
    else $error("code error on clean line");
  aligned_out_a: assert property (o_octet_valid |-> o_aligned)
    else $error("octet before alignment");
endmodule : csc_link_props

// ---- test/test_cell_scrambler_4b5b_codec.sv ----
/*
  Self-checking bench: tx end to rx end over one link, and a second rx
  end fed with hand-made line bits. Assumes a 10 MHz clock, i_ce high.
*/
module test_cell_scrambler_4b5b_codec;
  timeunit 1ns;
  timeprecision 1ns;
  import csc_pkg::*;

  localparam csc_code_t ENC [16] = '{5'h15, 5'h09, 5'h0a, 5'h0b, 5'h07, 5'h0d, 5'h0e,
    5'h0f, 5'h12, 5'h19, 5'h1a, 5'h1b, 5'h17, 5'h1d, 5'h1e, 5'h1f};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cell_valid = 1'b0;
  logic sync_ev = 1'b0;
  csc_octet_t cell_data = 8'h00;
  csc_octet_t octet, octet2;
  logic ready, underrun, oct_v, sop, eop, sync_o, code_e, aligned;
  logic oct_v2, sync2, code2, cmd2, abort2;
  logic took = 1'b0;
  logic lvl = 1'b0;
  logic prev = 1'b0;
  logic saw_xx = 1'b0;
  logic saw_x4 = 1'b0;
  logic ce2 = 1'b1;
  logic [9:0] sh = 10'h000;
  logic [4:0] flags = 5'h00;
  int err_count = 0;
  int n_compared = 0;
  int n_rx = 0;
  csc_octet_t exp_q[$];
  csc_octet_t q2[$];

  csc_link_if link_a();
  csc_link_if link_b();
  assign link_b.line = lvl;

  csc_tx #(.P_RESET_CYCLES(1000)) i_csc_tx (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_cell_valid(cell_valid), .i_cell_data(cell_data), .o_cell_ready(ready),
    .i_sync_event(sync_ev), .o_underrun(underrun), .link(link_a.tx_end));
  csc_rx i_csc_rx (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .link(link_a.rx_end),
    .o_octet(octet), .o_octet_valid(oct_v), .o_sop(sop), .o_eop(eop),
    .o_sync_event(sync_o), .o_code_err(code_e), .o_cmd_err(), .o_cell_abort(),
    .o_aligned(aligned));
  csc_rx i_csc_rx_2 (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce2), .link(link_b.rx_end),
    .o_octet(octet2), .o_octet_valid(oct_v2), .o_sop(), .o_eop(),
    .o_sync_event(sync2), .o_code_err(code2), .o_cmd_err(cmd2),
    .o_cell_abort(abort2), .o_aligned());
  csc_link_props i_csc_link_props (.i_clk(i_clk), .i_rst(i_rst), .line(link_a.line),
    .i_cell_valid(cell_valid), .o_cell_ready(ready), .i_sync_event(sync_ev),
    .o_underrun(underrun), .o_octet_valid(oct_v), .o_sop(sop), .o_eop(eop),
    .o_sync_event(sync_o), .o_code_err(code_e), .o_aligned(aligned),
    .o_code_err_b(code2), .o_octet_valid_b(oct_v2));

  always #50 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////
  // tasks
  function automatic logic [3:0] ref_nib(input int k);
    return PRNG_REF[63 - 4 * k -: 4];
  endfunction : ref_nib

  task automatic check(input csc_octet_t seen, input csc_octet_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wait_rx(input int n);
    int lim;
    lim = 0;
    while (n_rx < n)
    begin
      @(posedge i_clk);
      #10;
      lim++;
      if (lim > 20000)
      begin
        err_count++;
        $display("[ERR] %0t receive timeout", $time);
        stop_test();
      end
    end
  endtask : wait_rx

  task automatic send_sym(input csc_code_t c);
    for (int i = 4; i >= 0; i--)
    begin
      lvl = lvl ^ c[i];
      @(posedge i_clk);
      #10;
    end
  endtask : send_sym

  ////////////////////////////////////////////////////////////////////////
  // monitors
  always @(negedge i_clk)
  begin
    if (ready === 1'b1)
    begin
      exp_q.push_back(cell_valid ? cell_data : 8'h00);
      took = 1'b1;
    end
    if (oct_v === 1'b1)
    begin
      check(octet, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
      check({7'h00, sop}, {7'h00, n_rx % 53 == 0});
      check({7'h00, eop}, {7'h00, n_rx % 53 == 52});
      n_rx++;
    end
    if (oct_v2 === 1'b1)
      q2.push_back(octet2);
    flags = flags | {sync_o, sync2, code2, cmd2, abort2};
    sh = {sh[8:0], link_a.line ^ prev};
    prev = link_a.line;
    saw_xx = saw_xx | (sh == {ESC_SYMBOL, ESC_SYMBOL});
    saw_x4 = saw_x4 | (sh == {ESC_SYMBOL, ENC[ARG_START_KEEP]});
  end

  always @(posedge i_clk)
  begin
    if (took)
    begin
      took = 1'b0;
      #10 cell_data = 8'($urandom);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'hd745d9a5));
    repeat (8) @(posedge i_clk);
    #10 i_rst = 1'b0;
    cell_data = 8'hff;
    cell_valid = 1'b1;
    wait_rx(60);
    cell_valid = 1'b0;
    repeat (40) @(posedge i_clk);
    #10 cell_valid = 1'b1;
    wait_rx(160);
    sync_ev = 1'b1;
    @(posedge i_clk);
    #10 sync_ev = 1'b0;
    wait_rx(212);
    cell_valid = 1'b0;
    repeat (600) @(posedge i_clk);
    #10;
    check(8'(exp_q.size()), 8'h00);
    check({7'h00, saw_xx}, 8'h01);
    check({7'h00, saw_x4}, 8'h01);
    check({7'h00, flags[4]}, 8'h01);
    send_sym(ESC_SYMBOL);
    send_sym(ESC_SYMBOL);
    // enable low must freeze alignment and window
    ce2 = 1'b0;
    repeat (7) @(posedge i_clk);
    #10 ce2 = 1'b1;
    for (int k = 0; k < 16; k++)
      send_sym(ENC[4'(k) ^ ref_nib(k)]);
    send_sym(5'h00);
    send_sym(ESC_SYMBOL);
    send_sym(ENC[ARG_SYNC]);
    send_sym(ESC_SYMBOL);
    send_sym(ENC[4'h1]);
    repeat (20) @(posedge i_clk);
    #10;
    check(8'(q2.size()), 8'h08);
    for (int j = 0; j < 8; j++)
      check(q2[j], 8'(8'h22 * j + 8'h01));
    check({7'h00, flags[2]}, 8'h01);
    check({7'h00, flags[0]}, 8'h01);
    check({7'h00, flags[3]}, 8'h01);
    check({7'h00, flags[1]}, 8'h01);
    stop_test();
  end
endmodule : test_cell_scrambler_4b5b_codec
